// >>> hbps_pkg.sv
// Package for the half-bridge PWM sequencer: constants, state enums and carriers.
// Assumes a 100 MHz system clock; all figures become cycle counts here.
package hbps_pkg;

    // System clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // Fixed internal delay added to the falling ramp, ns
    localparam int DT_DELAY_NS = 125;
    // Least dead time allowed, ns
    localparam int DT_MIN_NS = 325;
    // Fixed delay as cycles, rounded up
    localparam logic [15:0] DT_DELAY_CYC =
        16'((DT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Least dead time as cycles, rounded up
    localparam logic [15:0] DT_MIN_CYC =
        16'((DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Oscillator cycles of bootstrap precharge at startup
    localparam logic [3:0] BOOT_CYCLES = 4'ha;
    // Counter widths
    localparam int CNT_W = 16;
    // Reset values of counters
    localparam logic [15:0] CNT_RST = 16'h0000;

    // Sequencer states, Gray along startup -> run path
    typedef enum logic [2:0] {
        HBPS_OFF      = 3'b000,  // Both gates off, waiting
        HBPS_BOOT     = 3'b001,  // Low side on, precharging bootstrap
        HBPS_DT_TO_HI = 3'b011,  // Dead time before high side
        HBPS_HIGH     = 3'b010,  // High side on
        HBPS_DT_TO_LO = 3'b110,  // Dead time before low side
        HBPS_LOW      = 3'b111   // Low side on
    } hbps_seq_t;

    // Overcurrent protection states
    typedef enum logic [1:0] {
        HBPS_OC_IDLE  = 2'b00,
        HBPS_OC_WARN  = 2'b01,
        HBPS_OC_STOP  = 2'b11
    } hbps_oc_t;

    // Comparator and supply inputs, raw
    typedef struct packed {
        logic burst_low;      // Control voltage below lower burst level
        logic burst_high;     // Control voltage above upper burst level
        logic pwm_trip;       // PWM comparator tripped
        logic oc_trip;        // Overcurrent comparator tripped
        logic dis_trip;       // Disable input above reference
        logic uvlo;           // Supply in undervoltage lockout
        logic below_restart;  // Supply below restart level
        logic below_on_m1;    // Supply below startup threshold minus 1 V
        logic at_on;          // Supply reached startup threshold
        logic soft_start;     // Soft-start ramp in progress
    } hbps_in_t;

    // Configuration counts
    typedef struct packed {
        logic [CNT_W-1:0] osc_period;  // Oscillator period, cycles
        logic [CNT_W-1:0] fall_ramp;   // Falling ramp length, cycles
    } hbps_cfg_t;

    // Outputs
    typedef struct packed {
        logic gate_hi;         // High-side gate command
        logic gate_lo;         // Low-side gate command
        logic pfc_shutdown_n;  // Low stops the PFC stage
        logic startup_en;      // Startup generator enable
        logic osc_pulse;       // Oscillator clock pulse
        logic even_pulse;      // Pulse classified even
        logic low_power;       // Reduced-consumption state
    } hbps_out_t;

endpackage

// >>> hbps_top.sv
// Half-bridge PWM sequencer: oscillator, gate sequencing, burst and fault latches.
// Assumes comparator results arrive as digital levels, clocked by clk_sys.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Burst low: gates off, oscillator stopped
// - Resume switching above upper burst level
// - PFC shutdown low only when burst idle
// - PFC shutdown released during undervoltage lockout
// - PWM trip ends high side, once per cycle
// - Overcurrent trip shuts down after qualification
// - First trip warns; clean cycle clears; second stops
// - Overcurrent stop latched until undervoltage lockout
// - After clear, startup waits for restart level
// - Disable input shuts down at once, low power
// - Disable latch released only by undervoltage lockout
// - Latched disable cycles startup generator periodically
// - One pulse per ramp, toggled odd/even
// - Even pulse: low off, dead time, high on
// - High off on PWM, overcurrent, odd pulse
// - Switching period is two oscillator periods
// - Startup low side held ten oscillator cycles
// - Burst restart: low first, high after second
// - Dead time is falling ramp plus delay
// - Dead time never below fixed minimum
// - Burst stop ignored during soft-start
module hbps_top
(
    input  wire logic              clk_sys,  // System clock, 100 MHz
    input  wire logic              rstn,     // Synchronous reset, active low
    input  wire hbps_pkg::hbps_in_t  in_raw, // Comparator and supply levels
    input  wire hbps_pkg::hbps_cfg_t cfg,    // Oscillator and ramp counts
    output var   hbps_pkg::hbps_out_t dout   // Gate and status outputs
);
    import hbps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State of the whole block
    typedef struct packed {
        hbps_in_t         sync1;      // First synchroniser stage
        hbps_in_t         sync2;      // Second synchroniser stage
        hbps_seq_t        seq;        // Gate sequencer state
        hbps_oc_t         oc;         // Overcurrent protection state
        logic             oc_seen;    // Warning armed: following cycle begun
        logic             pwm_done;   // PWM latch: turn-off used this cycle
        logic             burst_idle; // Stopped by burst mode
        logic             started;    // Bootstrap already done once
        logic             burst_pre;  // Burst restart precharge pending
        logic             dis_latch;  // Latched disable active
        logic             hold_start; // Startup held until restart level
        logic             hv_on;      // Startup generator on
        logic             odd_even;   // Toggle: 1 means next pulse even
        logic [3:0]       boot_cnt;   // Bootstrap oscillator cycles left
        logic [CNT_W-1:0] osc_cnt;    // Oscillator period counter
        logic [CNT_W-1:0] dt_cnt;     // Dead time counter
        hbps_out_t        o;          // Registered outputs
    } hbps_state_t;

    hbps_state_t st;       // Current state
    hbps_state_t next_st;  // Next state

    logic             pulse;    // Oscillator pulse this cycle
    logic [CNT_W-1:0] dt_len;   // Dead time in cycles
    logic             stop;     // Any cause holding gates off
    hbps_in_t         s;        // Synchronised inputs

    ////////////////////////////////////////////////////////////////////////////
    // Dead time: ramp plus fixed delay, clamped to the minimum
    always_comb
    begin
        dt_len = CNT_W'(cfg.fall_ramp + DT_DELAY_CYC);
        if (dt_len < DT_MIN_CYC)
        begin
            dt_len = DT_MIN_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_st = st;
        s       = st.sync2;
        // Two-stage synchroniser; only stage two is used below
        next_st.sync1 = in_raw;
        next_st.sync2 = st.sync1;

        // Burst stop and restart with hysteresis, ignored in soft-start
        if (s.soft_start)
        begin
            next_st.burst_idle = 1'b0;
        end
        else if (s.burst_low)
        begin
            next_st.burst_idle = 1'b1;
        end
        else if (s.burst_high && st.burst_idle)
        begin
            next_st.burst_idle = 1'b0;
            next_st.burst_pre  = st.started;
        end

        // Latched disable, released only by lockout
        if (s.uvlo)
        begin
            next_st.dis_latch = 1'b0;
        end
        else if (s.dis_trip)
        begin
            next_st.dis_latch = 1'b1;
        end

        // Any cause that forces both gates off and freezes the oscillator
        stop = st.burst_idle || st.dis_latch || s.dis_trip || s.uvlo
               || (st.oc == HBPS_OC_STOP);

        // Oscillator: stopped while halted, pulse at each period end
        // The counter restarts from zero, so the first pulse after a stop
        // comes one full period later
        pulse = 1'b0;
        if (stop)
        begin
            next_st.osc_cnt = CNT_RST;
        end
        else if (st.osc_cnt >= cfg.osc_period - 16'h0001)
        begin
            next_st.osc_cnt = CNT_RST;
            pulse           = 1'b1;
        end
        else
        begin
            next_st.osc_cnt = st.osc_cnt + 16'h0001;
        end
        if (pulse)
        begin
            next_st.odd_even = ~st.odd_even;
        end

        // Overcurrent qualification across switching cycles: the trip's own
        // cycle is not counted, but a trip held past its even pulse latches alone
        if (s.uvlo)
        begin
            if (st.oc == HBPS_OC_STOP)
            begin
                next_st.hold_start = 1'b1;
            end
            next_st.oc      = HBPS_OC_IDLE;
            next_st.oc_seen = 1'b0;
        end
        else
        begin
            case (st.oc)
                HBPS_OC_IDLE:
                begin
                    if (s.oc_trip)
                    begin
                        next_st.oc      = HBPS_OC_WARN;
                        next_st.oc_seen = 1'b0;
                    end
                end
                HBPS_OC_WARN:
                begin
                    if (s.oc_trip && st.oc_seen)
                    begin
                        // Trip again inside the following cycle
                        next_st.oc = HBPS_OC_STOP;
                    end
                    else if (pulse && st.odd_even)
                    begin
                        // Even pulse closes one switching cycle
                        if (st.oc_seen)
                        begin
                            next_st.oc      = HBPS_OC_IDLE;
                            next_st.oc_seen = 1'b0;
                        end
                        else
                        begin
                            next_st.oc_seen = 1'b1;      // Arm for next cycle
                        end
                    end
                end
                HBPS_OC_STOP:
                begin
                    next_st.oc = HBPS_OC_STOP;
                end
                default:
                begin
                    next_st.oc = HBPS_OC_IDLE;
                end
            endcase
        end

        // Gate sequencer
        // Dead time counter runs down to zero and parks there
        if (next_st.dt_cnt != CNT_RST)
        begin
            next_st.dt_cnt = st.dt_cnt - 16'h0001;
        end
        if (stop)
        begin
            next_st.seq = HBPS_OFF;
        end
        else
        begin
            case (st.seq)
                HBPS_OFF:
                begin
                    if (pulse)
                    begin
                        // First pulse turns the low side on
                        next_st.seq      = HBPS_BOOT;
                        // Short precharge only on a burst restart
                        next_st.boot_cnt = st.burst_pre ? 4'h1 : BOOT_CYCLES;
                    end
                end
                HBPS_BOOT:
                begin
                    if (pulse)
                    begin
                        if (st.boot_cnt <= 4'h1)
                        begin
                            next_st.seq       = HBPS_DT_TO_HI;
                            next_st.dt_cnt    = dt_len;
                            next_st.started   = 1'b1;
                            next_st.burst_pre = 1'b0;
                            next_st.odd_even  = 1'b0;
                            next_st.pwm_done  = 1'b0;
                        end
                        else
                        begin
                            next_st.boot_cnt = st.boot_cnt - 4'h1;
                        end
                    end
                end
                HBPS_DT_TO_HI:
                begin
                    // Low side already off; wait out the dead time
                    if (st.dt_cnt <= 16'h0001)
                    begin
                        next_st.seq = HBPS_HIGH;
                    end
                end
                HBPS_HIGH:
                begin
                    // PWM, overcurrent or the odd pulse ends the on-time; leaving
                    // the state is what stops a second turn-off in one cycle
                    if ((s.pwm_trip && !st.pwm_done) || s.oc_trip
                        || (pulse && !st.odd_even))
                    begin
                        next_st.seq      = HBPS_DT_TO_LO;
                        next_st.pwm_done = 1'b1;
                        next_st.dt_cnt   = dt_len;
                    end
                end
                HBPS_DT_TO_LO:
                begin
                    // High side already off; wait out the dead time
                    if (st.dt_cnt <= 16'h0001)
                    begin
                        next_st.seq = HBPS_LOW;
                    end
                end
                HBPS_LOW:
                begin
                    // Only the even pulse starts a new switching cycle
                    if (pulse && st.odd_even)
                    begin
                        next_st.seq      = HBPS_DT_TO_HI;
                        next_st.dt_cnt   = dt_len;
                        next_st.pwm_done = 1'b0;
                    end
                end
                default:
                begin
                    next_st.seq = HBPS_OFF;
                end
            endcase
        end
        if (s.uvlo)
        begin
            next_st.started   = 1'b0;                    // Full precharge again
            next_st.burst_pre = 1'b0;                    // Forget a pending restart
        end

        // Startup generator control
        // A hold set in this very cycle already forces the generator off,
        // and only a hold that stood since the last edge may be released
        if (st.hold_start || next_st.hold_start)
        begin
            next_st.hv_on = 1'b0;
            if (st.hold_start && s.below_restart)
            begin
                next_st.hold_start = 1'b0;
            end
        end
        else if (st.dis_latch)
        begin
            if (s.at_on)
            begin
                next_st.hv_on = 1'b0;
            end
            else if (s.below_on_m1)
            begin
                next_st.hv_on = 1'b1;
            end
        end
        else
        begin
            next_st.hv_on = s.uvlo && !s.at_on;
        end

        // Registered outputs
        next_st.o.gate_hi    = (next_st.seq == HBPS_HIGH);
        next_st.o.gate_lo    = (next_st.seq == HBPS_LOW)
                               || (next_st.seq == HBPS_BOOT);
        // Pulled low on the edge that turns the gates off, never before
        next_st.o.pfc_shutdown_n = s.uvlo || !st.burst_idle;
        next_st.o.startup_en = next_st.hv_on;
        next_st.o.osc_pulse  = pulse;
        next_st.o.even_pulse = pulse && st.odd_even;
        next_st.o.low_power  = next_st.dis_latch || next_st.burst_idle;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            // Everything clears; the Pfc_shutdown_n line is released
            st                  <= '0;
            st.o.pfc_shutdown_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs leave straight from the state register, free of glitches
    assign dout = st.o;

endmodule
`default_nettype wire

// >>> hbps_gate_model.sv
// Behavioural gate drivers and PFC stage on the far side of the sequencer.
// Assumes gate commands are sampled on the system clock.
`timescale 1ns/1ns
`default_nettype none
module hbps_gate_model
(
    input  wire logic clk_sys,        // System clock
    input  wire logic rstn,           // Reset, active low
    input  wire logic gate_hi,        // High-side command
    input  wire logic gate_lo,        // Low-side command
    input  wire logic pfc_shutdown_n, // Low stops the PFC stage
    output var logic  pfc_on,         // PFC stage running
    output var int    err_cnt         // Unsafe gate events
);
    logic boot_ok; // Bootstrap capacitor charged
    ////////////////////////////////////////////////////////////////////////////
    // Flags overlap and a high side fired from an empty bootstrap
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            boot_ok = 1'b0;
            err_cnt = 0;
        end
        else
        begin
            if (gate_hi && gate_lo)
                err_cnt++;
            if (gate_hi && !boot_ok)
                err_cnt++;
            if (gate_lo)
                boot_ok = 1'b1;
            else if (!pfc_shutdown_n)
                boot_ok = 1'b0;
        end
    end
    // PFC runs while its stop line is released
    assign pfc_on = pfc_shutdown_n;
endmodule
`default_nettype wire

// >>> hbps_chk.sv
// Port checker for the half-bridge sequencer.
// Assumes it is bound to every hbps_top instance.
`timescale 1ns/1ns
`default_nettype none
module hbps_chk
(
    input wire logic                clk_sys, // System clock
    input wire logic                rstn,    // Reset, active low
    input wire hbps_pkg::hbps_in_t  in_raw,  // Raw inputs
    input wire hbps_pkg::hbps_cfg_t cfg,     // Counts
    input wire hbps_pkg::hbps_out_t dout     // Outputs
);
    import hbps_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    logic [15:0] gap;      // Cycles with both gates off
    logic [1:0]  dis_hold; // Disable samples since lockout, saturating
    ////////////////////////////////////////////////////////////////////////////
    // Counts the idle gap between gate phases, saturating
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || dout.gate_hi || dout.gate_lo)
            gap <= CNT_RST;
        else if (gap != 16'hffff)
            gap <= gap + 16'h0001;
    end
    // Counts disable samples; any lockout sample starts over
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || in_raw.uvlo)
            dis_hold <= 2'h0;
        else if (in_raw.dis_trip && dis_hold != 2'h3)
            dis_hold <= dis_hold + 2'h1;
    end
    // Burst request held outside soft-start
    sequence s_burst_held;
        (in_raw.burst_low && !in_raw.soft_start)[*5];
    endsequence
    // Disable request held while supplied
    sequence s_dis_held;
        (in_raw.dis_trip && !in_raw.uvlo)[*5];
    endsequence
    a_no_overlap: assert property (!(dout.gate_hi && dout.gate_lo))
        else $error("both gates on");
    a_dead_gap: assert property
        (($rose(dout.gate_hi) || $rose(dout.gate_lo)) |-> gap >= DT_MIN_CYC)
        else $error("dead time too short");
    a_burst_stop: assert property
        (s_burst_held |=> !dout.gate_hi && !dout.gate_lo && !dout.osc_pulse)
        else $error("switching during burst stop");
    a_pfc_idle: assert property
        (!dout.pfc_shutdown_n |-> !dout.gate_hi && !dout.gate_lo)
        else $error("pfc stopped while switching");
    a_pfc_uvlo: assert property (in_raw.uvlo[*5] |-> dout.pfc_shutdown_n)
        else $error("pfc stopped in lockout");
    a_dis_stop: assert property
        (s_dis_held |=> dout.low_power && !dout.gate_hi && !dout.gate_lo)
        else $error("disable did not stop");
    a_dis_release: assert property
        (dis_hold == 2'h3 |-> dout.low_power)
        else $error("disable released without lockout");
    a_pulse_width: assert property (dout.osc_pulse |=> !dout.osc_pulse)
        else $error("clock pulse too long");
    a_even_pulse: assert property (dout.even_pulse |-> dout.osc_pulse)
        else $error("even mark without pulse");
    a_pwm_cut: assert property
        ($rose(in_raw.pwm_trip) && dout.gate_hi |-> ##[1:5] !dout.gate_hi)
        else $error("pwm trip ignored");
    a_oc_cut: assert property
        ($rose(in_raw.oc_trip) && dout.gate_hi |-> ##[1:5] !dout.gate_hi)
        else $error("overcurrent trip ignored");
endmodule
bind hbps_top hbps_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .in_raw(in_raw),
    .cfg(cfg), .dout(dout));
`default_nettype wire

// >>> half_bridge_pwm_sequencer_tb.sv
// Self-checking bench for the half-bridge sequencer.
// Assumes the gate model and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module half_bridge_pwm_sequencer_tb;
    import hbps_pkg::*;
    localparam int P = 100;      // Oscillator period, cycles
    logic      clk_sys = 1'b0;   // System clock
    logic      rstn    = 1'b0;   // Reset, active low
    hbps_in_t  ir;               // Raw inputs
    hbps_cfg_t cf;               // Counts
    hbps_out_t dq;               // Outputs
    logic      pfc_on;           // PFC model state
    int        gerr;             // Gate model errors
    int        err_total = 0;    // Mismatches
    int        checked = 0;      // Comparisons
    int        n;                // Cycles waited or counted
    int        ng;               // Cycles with a gate on
    always #5 clk_sys = ~clk_sys;
    hbps_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .in_raw(ir), .cfg(cf), .dout(dq));
    hbps_gate_model u_drv (.clk_sys(clk_sys), .rstn(rstn), .gate_hi(dq.gate_hi),
        .gate_lo(dq.gate_lo), .pfc_shutdown_n(dq.pfc_shutdown_n), .pfc_on(pfc_on),
        .err_cnt(gerr));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Compares one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask
    // Steps k falling edges
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    // Waits for a gate level; n gets the cycles spent
    task automatic wait_gate(input logic hi, input logic lvl, input int lim);
        n = 0;
        while (((hi ? dq.gate_hi : dq.gate_lo) !== lvl) && n < lim)
        begin
            tick(1);
            n++;
        end
        if (n >= lim)
        begin
            err_total++;
            $display("[FAIL] %0t gate wait timed out", $time);
            end_of_test();
        end
    endtask
    // Counts clock pulses into n and gate-on cycles into ng
    task automatic watch(input int k);
        n = 0;
        ng = 0;
        repeat (k)
        begin
            tick(1);
            n += int'(dq.osc_pulse === 1'b1);
            ng += int'(dq.gate_hi !== 1'b0 || dq.gate_lo !== 1'b0);
        end
    endtask
    // Expected dead time from the ramp count
    function automatic int dt_exp();
        int d;
        d = int'(cf.fall_ramp) + int'(DT_DELAY_CYC);
        return (d > int'(DT_MIN_CYC)) ? d : int'(DT_MIN_CYC);
    endfunction
    // Pulses one trip input for two cycles
    task automatic pulse_trip(input logic oc);
        if (oc)
            ir.oc_trip = 1'b1;
        else
            ir.pwm_trip = 1'b1;
        tick(2);
        ir.oc_trip = 1'b0;
        ir.pwm_trip = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Startup: bootstrap precharge, then dead time before high side
    task automatic sc_startup();
        wait_gate(1'b0, 1'b1, 2 * P);
        check(dq.gate_hi, 1'b0, "high during boot");
        wait_gate(1'b0, 1'b0, 12 * P);
        check(n >= 10 * P - 1 && n <= 10 * P + 1, 1'b1, "boot length");
        wait_gate(1'b1, 1'b1, 200);
        check(n, dt_exp(), "dead time long ramp");
    endtask
    // Steady run at the least dead time: phases and period
    task automatic sc_period();
        cf.fall_ramp = 16'h0005;
        wait_gate(1'b1, 1'b0, 2 * P);
        wait_gate(1'b1, 1'b1, 3 * P);
        wait_gate(1'b1, 1'b0, 2 * P);
        check(n, P - dt_exp(), "high on-time");
        wait_gate(1'b0, 1'b1, 200);
        check(n, dt_exp(), "dead time to low");
        wait_gate(1'b1, 1'b1, 3 * P);
        check(n, P, "low phase plus dead time");
    endtask
    // PWM trip ends high side once; a second trip is ignored
    task automatic sc_pwm();
        tick(10);
        pulse_trip(1'b0);
        wait_gate(1'b1, 1'b0, 10);
        wait_gate(1'b0, 1'b1, 200);
        check(n, dt_exp(), "dead time after trip");
        pulse_trip(1'b0);
        tick(5);
        check(dq.gate_lo, 1'b1, "second trip in cycle");
    endtask
    // Overcurrent: isolated trips recover, held trip latches until lockout
    task automatic sc_oc();
        repeat (2)
        begin
            wait_gate(1'b1, 1'b1, 3 * P);
            tick(5);
            pulse_trip(1'b1);
            wait_gate(1'b1, 1'b0, 10);
            wait_gate(1'b1, 1'b1, 3 * P);
            wait_gate(1'b1, 1'b0, 2 * P);
        end
        watch(2 * P);
        check(n, 2, "switching after warning");
        ir.oc_trip = 1'b1;
        tick(3 * P);
        ir.oc_trip = 1'b0;
        watch(4 * P);
        check(ng, 0, "overcurrent latched off");
        ir.at_on = 1'b0;
        ir.uvlo = 1'b1;
        tick(10);
        check(dq.startup_en, 1'b0, "startup held after clear");
        ir.below_restart = 1'b1;
        tick(10);
        check(dq.startup_en, 1'b1, "startup below restart");
        ir.below_restart = 1'b0;
        ir.at_on = 1'b1;
        ir.uvlo = 1'b0;
        wait_gate(1'b0, 1'b1, 3 * P);
        check(dq.startup_en, 1'b0, "startup off when running");
    endtask
    // Burst stop, soft-start masking, hysteresis and restart order
    task automatic sc_burst();
        wait_gate(1'b1, 1'b1, 12 * P);
        ir.soft_start = 1'b1;
        ir.burst_low = 1'b1;
        ir.burst_high = 1'b0;
        wait_gate(1'b1, 1'b0, 2 * P);
        wait_gate(1'b1, 1'b1, 3 * P);
        ir.soft_start = 1'b0;
        tick(6);
        check({dq.gate_hi, dq.gate_lo, pfc_on}, 3'h0, "burst idle");
        ir.burst_low = 1'b0;
        watch(2 * P);
        check(n, 0, "no pulses between thresholds");
        check(ng, 0, "no gates between thresholds");
        ir.burst_high = 1'b1;
        wait_gate(1'b0, 1'b1, 3 * P);
        check({dq.gate_hi, pfc_on}, 2'h1, "restart low side first");
        wait_gate(1'b0, 1'b0, 3 * P);
        check(n, P, "restart low until second pulse");
    endtask
    // Latched disable, periodic startup, release by lockout
    task automatic sc_disable();
        ir.at_on = 1'b0;
        ir.dis_trip = 1'b1;
        tick(3);
        ir.dis_trip = 1'b0;
        watch(3 * P);
        check({dq.low_power, ng == 0, n == 0}, 3'h7, "disable latched");
        ir.below_on_m1 = 1'b1;
        tick(6);
        ir.below_on_m1 = 1'b0;
        tick(6);
        check(dq.startup_en, 1'b1, "startup on below threshold");
        ir.at_on = 1'b1;
        tick(6);
        check(dq.startup_en, 1'b0, "startup off at threshold");
        ir.uvlo = 1'b1;
        tick(8);
        check(dq.low_power, 1'b0, "lockout release");
        ir.burst_low = 1'b1;
        tick(8);
        check(pfc_on, 1'b1, "pfc released in lockout");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        ir = '0;
        ir.burst_high = 1'b1;
        ir.at_on = 1'b1;
        cf.osc_period = 16'h0064;
        cf.fall_ramp = 16'h001e;
        tick(16);
        rstn = 1'b1;
        sc_startup();
        sc_period();
        sc_pwm();
        sc_oc();
        sc_burst();
        sc_disable();
        check(gerr, 0, "gate model");
        end_of_test();
    end
endmodule
`default_nettype wire
